/* common/mbsw_pkg.sv */
`default_nettype none
package mbsw_pkg;

  // function codes and protocol constants
  localparam logic [7:0]  MBSW_FN_WRITE1    = 8'h06;
  localparam logic [7:0]  MBSW_FN_DIAG      = 8'h08;
  localparam logic [7:0]  MBSW_FN_WRITEN    = 8'h10;
  localparam logic [7:0]  MBSW_EXC_FLAG     = 8'h80;
  localparam logic [7:0]  MBSW_EXC_FUNC     = 8'h01;
  localparam logic [7:0]  MBSW_EXC_ADDR     = 8'h02;
  localparam logic [7:0]  MBSW_EXC_VALUE    = 8'h03;
  localparam logic [7:0]  MBSW_BCAST_ADDR   = 8'h00;
  localparam logic [15:0] MBSW_DIAG_SUB     = 16'h0000;
  localparam logic [15:0] MBSW_MAX_REGS     = 16'h007D;  // 125
  localparam logic [7:0]  MBSW_MIN_BYTES    = 8'h02;
  localparam logic [7:0]  MBSW_MAX_BYTES    = 8'hFA;
  localparam logic [15:0] MBSW_HOLD_BASE    = 16'h9C41;  // 40001 decimal
  localparam logic [15:0] MBSW_CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] MBSW_CRC_POLY     = 16'hA001;
  localparam int          MBSW_HDR_BYTES    = 6;         // bytes up to register count
  localparam int          MBSW_BUF_BYTES    = 8;         // fixed-size query length
  localparam logic [7:0]  MBSW_SLAVE_RESET  = 8'h01;     // arbitrary default address

  // byte stream beat
  typedef struct packed {
    logic [7:0] data;
    logic       last;   // final byte of the frame
    logic       err;    // framing, parity, overrun or busy seen on this frame
  } mbsw_byte_s;

  // holding register write beat
  typedef struct packed {
    logic [15:0] index;  // address field, register number minus 40001
    logic [15:0] value;
  } mbsw_wr_s;

endpackage : mbsw_pkg
`default_nettype wire

/* rtl/mbsw_crc.sv */
`timescale 1ns/1ns
`default_nettype none
// one-byte step of the reflected crc-16 used on the serial line
module mbsw_crc
  import mbsw_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        clear,
  input  wire logic        step,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc
);
  logic [15:0] crc_q;
  logic [15:0] crc_d;

  // eight shift steps folded into one cycle
  always_comb begin
    crc_d = crc_q ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      crc_d = crc_d[0] ? ((crc_d >> 1) ^ MBSW_CRC_POLY) : (crc_d >> 1);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) crc_q <= MBSW_CRC_INIT;
    else if (clear) crc_q <= MBSW_CRC_INIT;
    else if (step) crc_q <= crc_d;
  end

  assign crc = crc_q;
endmodule : mbsw_crc
`default_nettype wire

/* rtl/mbsw_slave.sv */
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [R1] single write: addr, 06, reg, data, crc
// [R2] register field is holding number minus 40001
// [R3] single write data is two bytes
// [R4] address zero broadcasts writes, still performed
// [R5] addressed single write echoes whole query
// [R6] no response to broadcast queries
// [R7] master waits processing time after broadcast
// [R8] diagnostic subfunction zero echoes query unchanged
// [R9] diagnostic: subfunction then any data word
// [R10] diagnostic never broadcast; ignored if so
// [R11] multi write layout; reply echoes header
// [R12] multi write count at most 125
// [R13] byte count twice count, 2 to 250
// [R14] multi write words stored consecutively high first
// [R15] single write only to writable area
// [R16] illegal request gets exception reply
// [R17] errored frames discarded without reply
// [R18] crc checked; mismatch drops query
module mbsw_slave
  import mbsw_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  slave_addr,   // own station address
  input  wire mbsw_byte_s  rx_beat,
  input  wire logic        rx_valid,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic      [7:0]  tx_data,
  output logic             tx_last,
  output logic             wr_valid,
  output mbsw_wr_s         wr_beat,
  input  wire logic        wr_allowed,   // register map says index is writable
  output logic             busy          // master must not start a frame while high
);
  typedef enum {ST_RX, ST_CHECK, ST_WRITE, ST_TX, ST_DROP} mbsw_state_e;

  mbsw_state_e state_q;
  logic [7:0]  buf_q [MBSW_BUF_BYTES];
  logic [8:0]  cnt_q;
  logic [7:0]  data_cnt_q;
  logic [15:0] idx_q;
  logic [15:0] left_q;
  logic        err_q;
  logic        any_ok_q;
  logic [7:0]  tx_len_q;
  logic [7:0]  tx_pos_q;
  logic [15:0] crc_val;
  logic        crc_clear;
  logic        crc_step;
  logic [7:0]  crc_byte;
  logic [7:0]  lag0_q;
  logic [7:0]  lag1_q;

  // field views of the captured header
  wire [7:0]  f_addr  = buf_q[0];
  wire [7:0]  f_func  = buf_q[1];
  wire [15:0] f_w1    = {buf_q[2], buf_q[3]};
  wire [15:0] f_w2    = {buf_q[4], buf_q[5]};
  wire [7:0]  f_bytes = buf_q[6];
  wire        is_bcast = (f_addr == MBSW_BCAST_ADDR);                      // [R4]
  wire        for_us   = is_bcast || (f_addr == slave_addr);
  wire        rx_take  = rx_valid && (state_q == ST_RX);
  wire        is_multi = (f_func == MBSW_FN_WRITEN);
  // multi write byte count and register count checked together [R12] [R13]
  wire        multi_ok = (f_w2 != 16'h0000) && (f_w2 <= MBSW_MAX_REGS)
                         && (f_bytes >= MBSW_MIN_BYTES) && (f_bytes <= MBSW_MAX_BYTES)
                         && ({8'h00, f_bytes} == {f_w2[14:0], 1'b0});
  // expected total frame length; fixed layouts are eight bytes [R1] [R3] [R9] [R11]
  // nine bits wide: the longest multi write frame runs to 259 bytes
  wire [8:0]  exp_len  = is_multi ? 9'({1'b0, f_bytes} + 9'd9) : 9'(MBSW_BUF_BYTES);
  // at frame end the engine holds the crc of all but the last two bytes
  wire        crc_ok   = (crc_val == {lag0_q, lag1_q});                   // [R18]
  wire        func_ok  = (f_func == MBSW_FN_WRITE1) || (f_func == MBSW_FN_DIAG) || is_multi;
  wire        diag_bad = (f_func == MBSW_FN_DIAG) && (f_w1 != MBSW_DIAG_SUB);

  // receive crc engine: fed the byte two places back; reply bytes go to the second instance u_tx_crc
  assign crc_clear = (state_q == ST_RX) ? (cnt_q == 9'd0 && rx_take) : 1'b0;
  assign crc_step  = rx_take && (cnt_q >= 9'd2);
  assign crc_byte  = lag1_q;

  mbsw_crc u_crc (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clear    (crc_clear),
    .step     (crc_step),
    .data     (crc_byte),
    .crc      (crc_val)
  );

  // receive path: capture header, keep last two bytes as received crc
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= 9'h000;
      lag0_q <= 8'h00;
      lag1_q <= 8'h00;
      err_q  <= 1'b0;
    end else if (rx_take) begin
      lag1_q <= lag0_q;
      lag0_q <= rx_beat.data;
      err_q  <= (cnt_q == 9'd0) ? rx_beat.err : (err_q | rx_beat.err);
      cnt_q  <= rx_beat.last ? 9'h000 : ((cnt_q == 9'h1FF) ? cnt_q : 9'(cnt_q + 9'd1));
    end else if (state_q == ST_CHECK) begin
      cnt_q <= 9'h000;
    end
  end

  // final byte count is kept for the length check
  logic [8:0] flen_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) flen_q <= 9'h000;
    else if (rx_take && rx_beat.last) flen_q <= 9'(cnt_q + 9'd1);
  end

  // header bytes land in the buffer; the check state rewrites tail bytes for replies
  always_ff @(posedge core_clk) begin
    if (rx_take && cnt_q < 9'(MBSW_BUF_BYTES)) buf_q[cnt_q[2:0]] <= rx_beat.data;
    else if (state_q == ST_CHECK && func_ok && !diag_bad && !is_multi) begin
      buf_q[6] <= lag1_q;   // keep crc bytes for the echo [R5] [R8]
      buf_q[7] <= lag0_q;
    end
  end

  // fixed layouts must be exactly eight bytes, multi write as its byte count says
  wire len_match = is_multi ? (flen_q == exp_len) : (flen_q == 9'(MBSW_BUF_BYTES));

  // frame sequencing
  logic [7:0]  exc_q;
  logic        exc_on_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= ST_RX;
      exc_q      <= 8'h00;
      exc_on_q   <= 1'b0;
      idx_q      <= 16'h0000;
      left_q     <= 16'h0000;
      data_cnt_q <= 8'h00;
      any_ok_q   <= 1'b0;
      tx_len_q   <= 8'h00;
      tx_pos_q   <= 8'h00;
    end else begin
      case (state_q)
        ST_RX: begin
          if (rx_take && rx_beat.last) state_q <= ST_CHECK;
        end
        ST_CHECK: begin
          exc_on_q <= 1'b0;
          tx_pos_q <= 8'h00;
          idx_q    <= f_w1;                                                // [R2]
          left_q   <= is_multi ? f_w2 : 16'h0001;
          data_cnt_q <= 8'h00;
          any_ok_q <= 1'b0;
          if (err_q || !crc_ok || !for_us) begin
            state_q <= ST_RX;                                              // [R17] [R18]
          end else if (is_bcast && f_func == MBSW_FN_DIAG) begin
            state_q <= ST_RX;                                              // [R10]
          end else if (!func_ok || diag_bad) begin
            exc_q <= diag_bad ? MBSW_EXC_VALUE : MBSW_EXC_FUNC;            // [R16]
            exc_on_q <= 1'b1;
            tx_len_q <= 8'd5;
            state_q  <= is_bcast ? ST_RX : ST_TX;                          // [R6]
          end else if (!len_match || (is_multi && !multi_ok)) begin
            exc_q <= MBSW_EXC_VALUE;                                       // [R16]
            exc_on_q <= 1'b1;
            tx_len_q <= 8'd5;
            state_q  <= is_bcast ? ST_RX : ST_TX;
          end else if (f_func == MBSW_FN_DIAG) begin
            tx_len_q <= 8'd8;                                              // [R8]
            state_q  <= ST_TX;
          end else begin
            state_q <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          // one register per cycle; any writable one flagged [R14] [R15]
          if (left_q == 16'h0000) begin
            tx_len_q <= 8'd8;
            if (!any_ok_q) begin
              exc_q    <= MBSW_EXC_ADDR;                                   // [R16]
              exc_on_q <= 1'b1;
              tx_len_q <= 8'd5;
            end
            state_q <= is_bcast ? ST_RX : ST_TX;                           // [R4] [R6]
          end else begin
            any_ok_q   <= any_ok_q | wr_allowed;
            idx_q      <= 16'(idx_q + 16'd1);
            left_q     <= 16'(left_q - 16'd1);
            data_cnt_q <= 8'(data_cnt_q + 8'd2);
          end
        end
        ST_TX: begin
          if (tx_ready) begin
            tx_pos_q <= 8'(tx_pos_q + 8'd1);
            if (tx_pos_q == 8'(tx_len_q - 8'd1)) state_q <= ST_RX;
          end
        end
        default: state_q <= ST_RX;
      endcase
    end
  end

  // multi write data words are read back from a data store filled on receive
  logic [7:0] wdat_q [256];
  always_ff @(posedge core_clk) begin
    if (rx_take && cnt_q >= 9'd7) wdat_q[8'(cnt_q - 9'd7)] <= rx_beat.data;
  end

  // write port: single write uses data field, multi write walks the store [R14]
  assign wr_valid = (state_q == ST_WRITE) && (left_q != 16'h0000) && wr_allowed;
  assign wr_beat.index = idx_q;
  assign wr_beat.value = is_multi ? {wdat_q[data_cnt_q], wdat_q[8'(data_cnt_q + 8'd1)]} : f_w2;

  // reply bytes: echo for 06 and 08, header plus fresh crc for 10 and exceptions [R5] [R11]
  logic [7:0] rep_byte;
  logic [7:0] tx_crc_lo_q;
  logic [7:0] tx_crc_hi_q;
  logic [7:0] body_byte;
  always_comb begin
    body_byte = buf_q[tx_pos_q[2:0]];
    if (exc_on_q) begin
      case (tx_pos_q)
        8'd1:    body_byte = f_func | MBSW_EXC_FLAG;
        8'd2:    body_byte = exc_q;
        default: body_byte = buf_q[0];
      endcase
    end
    rep_byte = body_byte;
    if ((exc_on_q || is_multi) && tx_pos_q == 8'(tx_len_q - 8'd2)) rep_byte = tx_crc_lo_q;
    if ((exc_on_q || is_multi) && tx_pos_q == 8'(tx_len_q - 8'd1)) rep_byte = tx_crc_hi_q;
  end

  // reply crc built on the fly with a second engine instance
  logic [15:0] tx_crc;
  wire tx_step = (state_q == ST_TX) && tx_ready && (tx_pos_q < 8'(tx_len_q - 8'd2));
  mbsw_crc u_tx_crc (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clear    (state_q == ST_CHECK),
    .step     (tx_step),
    .data     (rep_byte),
    .crc      (tx_crc)
  );
  assign tx_crc_lo_q = tx_crc[7:0];
  assign tx_crc_hi_q = tx_crc[15:8];

  assign tx_valid = (state_q == ST_TX);
  assign tx_data  = tx_valid ? rep_byte : 8'h00;
  assign tx_last  = tx_valid && (tx_pos_q == 8'(tx_len_q - 8'd1));
  assign busy     = (state_q != ST_RX);   // broadcast has no reply, master waits on this [R7]
endmodule : mbsw_slave
`default_nettype wire

/* verif/mbsw_slave_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module mbsw_slave_sva
  import mbsw_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic [7:0] slave_addr,
  input wire mbsw_byte_s rx_beat,
  input wire logic       rx_valid,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic       tx_last,
  input wire logic       wr_valid,
  input wire mbsw_wr_s   wr_beat,
  input wire logic       wr_allowed,
  input wire logic       busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic       sof_q, bc_q, txf_q;
  logic [7:0] adr_q;
  wire        take = rx_valid && !busy;
  // remembers the query address so the reply can be tied to it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sof_q <= 1'b1;
      bc_q  <= 1'b0;
      txf_q <= 1'b1;
      adr_q <= 8'h00;
    end else begin
      if (take)
        sof_q <= rx_beat.last;
      if (take && sof_q)
        adr_q <= rx_beat.data;
      if (take && sof_q)
        bc_q <= (rx_beat.data == 8'h00);
      if (tx_valid && tx_ready)
        txf_q <= tx_last;
    end
  end
  a_reply_stands: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte moved before taken");
  a_busy_on_last: assert property (take && rx_beat.last |=> busy)
    else $error("busy not raised after last byte");
  a_tx_in_busy: assert property (tx_valid |-> busy)
    else $error("reply outside busy");
  a_wr_in_busy: assert property (wr_valid |-> busy && !tx_valid)
    else $error("write outside processing");
  a_err_dropped: assert property (take && rx_beat.last && rx_beat.err |=> (!tx_valid && !wr_valid) [*8])
    else $error("errored frame acted on");
  a_bcast_silent: assert property (tx_valid |-> !bc_q)
    else $error("reply to broadcast");
  a_reply_addr: assert property (tx_valid && txf_q |-> tx_data == adr_q)
    else $error("reply does not start with address");
  a_last_ends: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("reply runs past last byte");
  c_stall: cover property (tx_valid && !tx_ready);
  c_reply: cover property (tx_valid && tx_ready && tx_last);
  c_write: cover property (wr_valid);
endmodule : mbsw_slave_sva
`default_nettype wire

/* verif/mbsw_master_model.sv */
`timescale 1ns/1ns
`default_nettype none
// behavioural bus master: sends query bytes, takes reply bytes
module mbsw_master_model
  import mbsw_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       busy,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       slow,
  output var  mbsw_byte_s rx_beat,
  output var  logic       rx_valid,
  output logic            tx_ready
);
  logic [7:0] got[$];
  logic       ph_q = 1'b0;
  initial begin
    rx_beat = '0;
    rx_valid = 1'b0;
  end
  // stalls every other cycle when slow, so reply bytes must stand
  assign tx_ready = !slow || ph_q;
  always @(posedge core_clk) begin
    ph_q <= !ph_q;
    if (tx_valid === 1'b1 && tx_ready)
      got.push_back(tx_data);
  end
  // a frame starts once the slave is idle again, or after 3000 cycles of waiting
  task automatic send(input logic [7:0] f[$], input logic err);
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 3000) begin
      @(negedge core_clk);
      i++;
    end
    @(posedge core_clk);
    foreach (f[k]) begin
      rx_beat <= '{data: f[k], last: k == f.size() - 1, err: err && k == f.size() - 1};
      rx_valid <= 1'b1;
      @(posedge core_clk);
    end
    rx_valid <= 1'b0;
    rx_beat.data <= ~f[f.size() - 1];  // idle line shows no stale byte
    rx_beat.last <= 1'b0;
    rx_beat.err  <= 1'b0;
  endtask : send
endmodule : mbsw_master_model
`default_nettype wire

/* verif/mbsw_slave_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module mbsw_slave_tb_top
  import mbsw_pkg::*;
;
  typedef logic [7:0] mbsw_q_t[$];
  logic       core_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] slave_addr = 8'h2A;
  logic       wr_allowed = 1'b1;
  logic       slow = 1'b0;
  logic       tx_valid, tx_ready, tx_last, wr_valid, busy, rx_valid;
  logic [7:0] tx_data;
  mbsw_byte_s rx_beat;
  mbsw_wr_s   wr_beat;
  mbsw_wr_s   wq[$];
  mbsw_q_t    e;
  int         n_errors = 0;
  int         total_checks = 0;
  always #5 core_clk = ~core_clk;
  mbsw_slave DUT (.core_clk(core_clk), .arst_n(arst_n), .slave_addr(slave_addr),
    .rx_beat(rx_beat), .rx_valid(rx_valid), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_last(tx_last), .wr_valid(wr_valid), .wr_beat(wr_beat),
    .wr_allowed(wr_allowed), .busy(busy));
  mbsw_master_model u_master (.core_clk(core_clk), .busy(busy), .tx_valid(tx_valid),
    .tx_data(tx_data), .slow(slow), .rx_beat(rx_beat), .rx_valid(rx_valid),
    .tx_ready(tx_ready));
  // log of every register write, in order
  always @(posedge core_clk) begin
    if (wr_valid === 1'b1)
      wq.push_back(wr_beat);
  end
  function automatic mbsw_q_t crcd(input mbsw_q_t f);
    logic [15:0] c;
    c = MBSW_CRC_INIT;
    foreach (f[k]) begin
      c = c ^ {8'h00, f[k]};
      repeat (8)
        c = c[0] ? (c >> 1) ^ MBSW_CRC_POLY : c >> 1;
    end
    f.push_back(c[7:0]);  // low byte first
    f.push_back(c[15:8]);
    return f;
  endfunction : crcd
  function automatic mbsw_q_t exc(input logic [7:0] fn, input logic [7:0] code);
    mbsw_q_t r;
    r = {slave_addr, fn + MBSW_EXC_FLAG, code};
    return crcd(r);
  endfunction : exc
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  // one query, then the whole reply and the write count are judged
  task automatic xact(input mbsw_q_t f, input logic err, input mbsw_q_t rep, input int nw);
    int i;
    i = 0;
    u_master.got.delete();
    wq.delete();
    u_master.send(f, err);
    repeat (3) @(negedge core_clk);
    while (busy !== 1'b0 && i < 3000) begin
      @(negedge core_clk);
      i++;
    end
    if (i == 3000) begin
      n_errors++;
      $display("[FAIL] busy expected 0 seen 1");
      summarize();
    end
    chk("reply length", rep.size(), u_master.got.size());
    foreach (rep[k])
      chk("reply byte", rep[k], u_master.got[k]);
    chk("write count", nw, wq.size());
  endtask : xact
  task automatic t_single();
    mbsw_q_t f;
    f = {slave_addr, MBSW_FN_WRITE1, 8'h00, 8'h01, 8'h17, 8'h70};
    f = crcd(f);
    xact(f, 1'b0, f, 1);
    chk("index", 16'h0001, wq[0].index);
    chk("value", 16'h1770, wq[0].value);
    $display("single write done");
  endtask : t_single
  task automatic t_bcast();
    mbsw_q_t f;
    f = {MBSW_BCAST_ADDR, MBSW_FN_WRITE1, 8'h00, 8'h0D, 8'h12, 8'h34};
    xact(crcd(f), 1'b0, e, 1);
    f = {MBSW_BCAST_ADDR, MBSW_FN_WRITEN, 8'h00, 8'h03, 8'h00, 8'h01, 8'h02, 8'hBE, 8'hEF};
    xact(crcd(f), 1'b0, e, 1);
    $display("broadcast done");
  endtask : t_bcast
  task automatic t_diag();
    mbsw_q_t    f;
    logic [7:0] d;
    for (int k = 0; k < 2; k++) begin
      d = k ? 8'hFF : 8'h00;
      f = {slave_addr, MBSW_FN_DIAG, MBSW_DIAG_SUB[15:8], MBSW_DIAG_SUB[7:0], d, d};
      f = crcd(f);
      xact(f, 1'b0, f, 0);
    end
    f = {MBSW_BCAST_ADDR, MBSW_FN_DIAG, 8'h00, 8'h00, 8'h12, 8'h34};
    xact(crcd(f), 1'b0, e, 0);
    $display("diagnostic done");
  endtask : t_diag
  task automatic t_multi();
    mbsw_q_t f;
    @(posedge core_clk);
    slow <= 1'b1;
    f = {slave_addr, MBSW_FN_WRITEN, 8'h00, 8'h05, 8'h00, 8'h02, 8'h04};
    f = {f, 8'h12, 8'h34, 8'hAB, 8'hCD};
    xact(crcd(f), 1'b0, crcd(f[0:5]), 2);
    chk("word 0", 32'h00051234, wq[0]);
    chk("word 1", 32'h0006ABCD, wq[1]);
    f = {slave_addr, MBSW_FN_WRITEN, 8'h00, 8'h00, 8'h00, 8'h7D, 8'hFA};
    repeat (250) f.push_back(8'h5A);
    xact(crcd(f), 1'b0, crcd(f[0:5]), 125);
    f[5] = 8'h7E;
    f[6] = 8'hFC;
    f = {f, 8'h5A, 8'h5A};
    xact(crcd(f), 1'b0, exc(MBSW_FN_WRITEN, MBSW_EXC_VALUE), 0);
    f = {slave_addr, MBSW_FN_WRITEN, 8'h00, 8'h05, 8'h00, 8'h02, 8'h03, 8'h01, 8'h02, 8'h03};
    xact(crcd(f), 1'b0, exc(MBSW_FN_WRITEN, MBSW_EXC_VALUE), 0);
    slow <= 1'b0;
    $display("multiple write done");
  endtask : t_multi
  task automatic t_errs();
    mbsw_q_t f;
    f = {slave_addr, MBSW_FN_WRITE1, 8'h00, 8'h02, 8'h00, 8'h07};
    f = crcd(f);
    f[7] = ~f[7];
    xact(f, 1'b0, e, 0);
    f[7] = ~f[7];
    xact(f, 1'b1, e, 0);
    @(posedge core_clk);
    wr_allowed <= 1'b0;
    xact(f, 1'b0, exc(MBSW_FN_WRITE1, MBSW_EXC_ADDR), 0);
    wr_allowed <= 1'b1;
    f = {slave_addr, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
    xact(crcd(f), 1'b0, exc(8'h05, MBSW_EXC_FUNC), 0);
    $display("error cases done");
  endtask : t_errs
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    t_single();
    t_bcast();
    t_diag();
    t_multi();
    t_errs();
    summarize();
  end
endmodule : mbsw_slave_tb_top
bind mbsw_slave mbsw_slave_sva u_sva (.core_clk(core_clk), .arst_n(arst_n),
  .slave_addr(slave_addr), .rx_beat(rx_beat), .rx_valid(rx_valid), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .wr_valid(wr_valid),
  .wr_beat(wr_beat), .wr_allowed(wr_allowed), .busy(busy));
`default_nettype wire
